// >>> rtl/fsi_sleep_id.sv
// sleep entry, release and identification read logic of a serial flash
// Behaviour
// [RULE1] Sleep is entered only by its command; asleep, writes are ignored.
// [RULE2] Deselecting gives standby; deselecting alone never enters sleep.
// [RULE3] Asleep, every command except release-and-identify is ignored.
// [RULE4] Power-up (reset) starts in standby, never asleep.
// [RULE5] Sleep runs only if select rises right after its eighth bit.
// [RULE6] Sleep is entered only after the sleep entry delay.
// [RULE7] Sleep command during a write cycle is rejected, cycle unaffected.
// [RULE8] Release byte alone wakes; nothing accepted until wake delay ends.
// [RULE9] Release plus three dummy bytes shifts device code out MSB first.
// [RULE10] Device code repeats while clocks continue; select high ends it.
// [RULE11] Release with ID read from sleep waits the longer wake delay.
// [RULE12] Release command while write flag is one is ignored.
// [RULE13] Single ID read: command, zero address, then maker then device code.
// [RULE14] Address one on any ID read gives device code first.
// [RULE15] Dual ID read sends both codes on two lines, MSB first.
// [RULE16] Quad ID read: address, four dummy clocks, codes on four lines.
// [RULE17] Write flag reads one throughout a self-timed cycle, then zero.
// [RULE18] Data lines float except while shifting identification bits.
// [RULE19] Maker and device codes are each one byte, eight bits.
`timescale 1ns/1ps
`default_nettype none

module fsi_sleep_id #(
	parameter logic [7:0] MAKER_CODE       = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_CODE      = 8'hC3, // arbitrary value
	parameter int         SLEEP_ENTRY_NS   = fsi_pkg::SLEEP_ENTRY_NS,
	parameter int         WAKE_NS          = fsi_pkg::WAKE_NS,
	parameter int         WAKE_AFTER_ID_NS = fsi_pkg::WAKE_AFTER_ID_NS
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic                     sclk,
	input  wire logic                     selectN,
	input  wire logic [fsi_pkg::IO_W-1:0] ioIn,
	output logic      [fsi_pkg::IO_W-1:0] ioOut_q,
	output logic      [fsi_pkg::IO_W-1:0] ioOe_q,
	input  wire logic                     writeInProgressFlag,
	output logic                          writeInProgressOut_q,
	output logic                          sleepMode_q,
	output logic                          cmdGate_q
);
	import fsi_pkg::*;

	localparam logic [TMR_W-1:0] SLEEP_LD =
		TMR_W'(nsToCycles(SLEEP_ENTRY_NS) - 1);
	localparam logic [TMR_W-1:0] WAKE_LD =
		TMR_W'(nsToCycles(WAKE_NS) - 1);
	localparam logic [TMR_W-1:0] WAKE_ID_LD =
		TMR_W'(nsToCycles(WAKE_AFTER_ID_NS) - 1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic fsi_lane_s laneOf(input logic [7:0] c);
		fsi_lane_s l;
		l = '{start: START_X1, a0: A0_X1, oe: OE_X1, step: STEP_X1};
		if (c == CMD_ID_X2) begin
			l = '{start: START_X2, a0: A0_X2, oe: OE_X2, step: STEP_X2};
		end else if (c == CMD_ID_X4) begin
			l = '{start: START_X4, a0: A0_X4, oe: OE_X4, step: STEP_X4};
		end
		return l;
	endfunction : laneOf

	function automatic logic cmdOk(input logic [7:0] c,
		input fsi_core_s s);
		logic ok;
		ok = 1'h0;
		if (s.busy || s.write_in_progress_flag) begin
			ok = 1'h0; // RULE7 RULE8 RULE12
		end else if (c == CMD_RELEASE) begin
			ok = 1'h1;
		end else if (!s.asleep) begin
			ok = (c == CMD_SLEEP) || (c == CMD_ID_X1) ||
				(c == CMD_ID_X2) || (c == CMD_ID_X4);
		end
		// RULE1 RULE3
		return ok;
	endfunction : cmdOk

	// ----------------------------------------------------------------
	// link side: serial clock domain
	// ----------------------------------------------------------------
	// select high clears the frame; sclk stands still between frames
	logic             frameRstN;
	logic [CNT_W-1:0] bitCnt_q;
	logic [CNT_W-1:0] bitNext;
	logic [7:0]       shiftIn_q;
	logic [7:0]       byteNow;
	logic [7:0]       cmd_q;
	logic             acc_q;
	logic             devFirst_q;
	logic [3:0]       outIdx_q;
	fsi_core_s        coreS1_q;
	fsi_core_s        coreS2_q;
	fsi_core_s        coreOut_q;
	fsi_rep_s         rep_q;
	fsi_lane_s        lane;
	logic [15:0]      idWord;
	logic [15:0]      rotWord;
	logic             dataAct;

	assign frameRstN = rstn & ~selectN;
	assign bitNext   = (bitCnt_q == BITS_SAT) ? bitCnt_q : bitCnt_q + CNT_ONE;
	assign byteNow   = {shiftIn_q[6:0], ioIn[0]};
	assign lane      = laneOf(cmd_q);
	assign dataAct   = acc_q && (cmd_q != CMD_SLEEP) &&
		(bitCnt_q >= lane.start);

	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			coreS1_q <= '0;
			coreS2_q <= '0;
		end else begin
			coreS1_q <= coreOut_q;
			coreS2_q <= coreS1_q;
		end
	end

	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			bitCnt_q  <= '0;
			shiftIn_q <= '0;
		end else begin
			bitCnt_q  <= bitNext;
			shiftIn_q <= byteNow;
		end
	end

	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			cmd_q <= '0;
			acc_q <= 1'h0;
		end else if (bitNext == BITS_CMD) begin
			cmd_q <= byteNow;
			acc_q <= cmdOk(byteNow, coreS2_q); // RULE3 RULE7 RULE12
		end
	end

	// lowest address bit decides the byte order
	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			devFirst_q <= 1'h0;
		end else if (acc_q && cmd_q != CMD_RELEASE &&
			bitNext == lane.a0) begin
			devFirst_q <= ioIn[0]; // RULE14
		end
	end

	// report levels survive the frame so the core can read them late
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			rep_q <= '0;
		end else begin
			if (bitCnt_q == '0) begin
				rep_q.frameTgl <= ~rep_q.frameTgl;
			end
			// any ninth clock cancels the sleep request
			rep_q.sleep <= (bitNext == BITS_CMD) &&
				(byteNow == CMD_SLEEP) && cmdOk(byteNow, coreS2_q); // RULE5
			rep_q.wakeShort <= (bitNext == BITS_CMD) &&
				(byteNow == CMD_RELEASE) && cmdOk(byteNow, coreS2_q); // RULE8
			rep_q.wakeLong <= (bitNext > BITS_CMD) && acc_q &&
				(cmd_q == CMD_RELEASE); // RULE11
		end
	end

	always_comb begin
		if (cmd_q == CMD_RELEASE) begin
			idWord = {DEVICE_CODE, DEVICE_CODE}; // RULE9 RULE19
		end else if (devFirst_q) begin
			idWord = {DEVICE_CODE, MAKER_CODE}; // RULE14
		end else begin
			idWord = {MAKER_CODE, DEVICE_CODE}; // RULE13 RULE19
		end
	end

	assign rotWord = idWord << outIdx_q;

	// outputs change on falling edges; index wrap repeats the codes
	always_ff @(negedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			ioOut_q  <= '0;
			ioOe_q   <= '0; // RULE18
			outIdx_q <= '0;
		end else if (dataAct) begin
			ioOe_q   <= lane.oe; // RULE18
			outIdx_q <= outIdx_q + lane.step; // RULE10
			if (lane.oe == OE_X4) begin
				ioOut_q <= rotWord[15:12]; // RULE16
			end else if (lane.oe == OE_X2) begin
				ioOut_q <= {2'h0, rotWord[15:14]}; // RULE15
			end else begin
				ioOut_q <= {2'h0, rotWord[15], 1'h0}; // RULE9 RULE13
			end
		end else begin
			ioOe_q <= '0;
		end
	end

	// ----------------------------------------------------------------
	// core side: reference clock domain
	// ----------------------------------------------------------------
	logic             selS1_q;
	logic             selS2_q;
	logic             selS3_q;
	fsi_rep_s         repS1_q;
	fsi_rep_s         repS2_q;
	logic             tglSeen_q;
	logic             act;
	logic             sleepHit;
	logic             wakeShortHit;
	logic             wakeLongHit;
	fsi_state_e       state_q;
	logic [TMR_W-1:0] tmr_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			selS1_q <= 1'h1;
			selS2_q <= 1'h1;
			selS3_q <= 1'h1;
			repS1_q <= '0;
			repS2_q <= '0;
		end else begin
			selS1_q <= selectN;
			selS2_q <= selS1_q;
			selS3_q <= selS2_q;
			repS1_q <= rep_q;
			repS2_q <= repS1_q;
		end
	end

	// a frame counts once, and only if sclk ran in it
	assign act = selS2_q && !selS3_q &&
		(repS2_q.frameTgl != tglSeen_q);
	assign sleepHit     = act && repS2_q.sleep && !writeInProgressFlag;
	assign wakeShortHit = act && repS2_q.wakeShort;
	assign wakeLongHit  = act && repS2_q.wakeLong;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tglSeen_q <= 1'h0;
		end else if (act) begin
			tglSeen_q <= repS2_q.frameTgl;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_STANDBY; // RULE4
			tmr_q   <= '0;
		end else begin
			case (state_q)
			ST_STANDBY: begin
				if (sleepHit) begin
					state_q <= ST_ENTER; // RULE1 RULE7
					tmr_q   <= SLEEP_LD;
				end else if (wakeShortHit) begin
					state_q <= ST_WAKE; // RULE8
					tmr_q   <= WAKE_LD;
				end
			end
			ST_ENTER: begin
				if (tmr_q == '0) begin
					state_q <= ST_SLEEP; // RULE6
				end else begin
					tmr_q <= tmr_q - TMR_ONE;
				end
			end
			ST_SLEEP: begin
				if (wakeShortHit) begin
					state_q <= ST_WAKE; // RULE3 RULE8
					tmr_q   <= WAKE_LD;
				end else if (wakeLongHit) begin
					state_q <= ST_WAKE; // RULE11
					tmr_q   <= WAKE_ID_LD;
				end
			end
			default: begin
				if (tmr_q == '0) begin
					state_q <= ST_STANDBY; // RULE2
				end else begin
					tmr_q <= tmr_q - TMR_ONE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			coreOut_q            <= '0;
			sleepMode_q          <= 1'h0;
			cmdGate_q            <= 1'h0;
			writeInProgressOut_q <= 1'h0;
		end else begin
			coreOut_q.asleep     <= state_q == ST_SLEEP;
			coreOut_q.busy       <= (state_q == ST_ENTER) ||
				(state_q == ST_WAKE);
			coreOut_q.write_in_progress_flag        <= writeInProgressFlag;
			sleepMode_q          <= state_q == ST_SLEEP;
			// other command decoders may run only in standby
			cmdGate_q            <= state_q == ST_STANDBY; // RULE1 RULE8
			writeInProgressOut_q <= writeInProgressFlag; // RULE17
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence seqEnterArm;
		sleepHit ##1 (state_q == ST_ENTER && tmr_q == SLEEP_LD);
	endsequence

	sequence seqEnterDone;
		(state_q == ST_ENTER && tmr_q == '0) ##1 state_q == ST_SLEEP;
	endsequence

	AST_SLEEP_VIA_CMD: assert property ( // RULE1
		@(posedge ref_clk) disable iff (!rstn)
		(state_q == ST_STANDBY ##1 state_q == ST_ENTER)
		|-> $past(sleepHit))
		else $error("sleep entered without a sleep command");

	AST_DESELECT_STAYS_AWAKE: assert property ( // RULE2
		@(posedge ref_clk) disable iff (!rstn)
		(state_q == ST_STANDBY && !sleepHit)
		|=> state_q inside {ST_STANDBY, ST_WAKE})
		else $error("deselection moved toward sleep");

	AST_SLEEP_LEAVES_ON_RELEASE: assert property ( // RULE3
		@(posedge ref_clk) disable iff (!rstn)
		(state_q == ST_SLEEP && !wakeShortHit && !wakeLongHit)
		|=> state_q == ST_SLEEP)
		else $error("sleep left without release command");

	AST_ENTER_DELAY: assert property ( // RULE6
		@(posedge ref_clk) disable iff (!rstn)
		seqEnterArm |-> ##1 (state_q == ST_ENTER &&
		tmr_q == SLEEP_LD - TMR_ONE))
		else $error("sleep entry delay not counted");

	AST_ENTER_ENDS: assert property ( // RULE6
		@(posedge ref_clk) disable iff (!rstn)
		(state_q == ST_ENTER && tmr_q == '0) |-> seqEnterDone)
		else $error("sleep not entered after entry delay");

	AST_WAKE_DELAY: assert property ( // RULE8
		@(posedge ref_clk) disable iff (!rstn)
		(state_q inside {ST_STANDBY, ST_SLEEP} && wakeShortHit)
		|=> (state_q == ST_WAKE && tmr_q == WAKE_LD) ##1 !cmdGate_q)
		else $error("wake delay not started");

	AST_WAKE_ID_DELAY: assert property ( // RULE11
		@(posedge ref_clk) disable iff (!rstn)
		(state_q == ST_SLEEP && wakeLongHit && !wakeShortHit)
		|=> state_q == ST_WAKE && tmr_q == WAKE_ID_LD)
		else $error("long wake delay not started");

	AST_SLEEP_REJECT_WIP: assert property ( // RULE7
		@(posedge sclk) disable iff (!frameRstN)
		(coreS2_q.write_in_progress_flag && bitNext == BITS_CMD) |=> !rep_q.sleep)
		else $error("sleep accepted during write cycle");

	AST_RELEASE_REJECT_WIP: assert property ( // RULE12
		@(posedge sclk) disable iff (!frameRstN)
		(coreS2_q.write_in_progress_flag && bitNext == BITS_CMD) |=> !acc_q)
		else $error("release accepted during write cycle");

	AST_FLOAT_OUTSIDE_DATA: assert property ( // RULE18
		@(negedge sclk) disable iff (!frameRstN)
		(ioOe_q != '0) |-> (bitCnt_q > BITS_CMD && cmd_q != CMD_SLEEP))
		else $error("data lines driven outside data phase");

endmodule : fsi_sleep_id

`default_nettype wire

// >>> inc/fsi_pkg.sv
// package: constants and carriers for the sleep and identify block
package fsi_pkg;

	// ----------------------------------------------------------------
	// widths and clock
	// ----------------------------------------------------------------
	localparam int IO_W          = 4;
	localparam int CNT_W         = 6;
	localparam int TMR_W         = 16;
	localparam int CLK_PERIOD_NS = 4;

	// ----------------------------------------------------------------
	// command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_SLEEP   = 8'hB9;
	localparam logic [7:0] CMD_RELEASE = 8'hAB;
	localparam logic [7:0] CMD_ID_X1   = 8'h90;
	localparam logic [7:0] CMD_ID_X2   = 8'h92;
	localparam logic [7:0] CMD_ID_X4   = 8'h94;

	// ----------------------------------------------------------------
	// serial clock counts, lanes and delays
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] BITS_CMD = 6'h08;
	localparam logic [CNT_W-1:0] BITS_SAT = 6'h3F;
	localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
	localparam logic [CNT_W-1:0] A0_X1    = 6'h20;
	localparam logic [CNT_W-1:0] A0_X2    = 6'h14;
	localparam logic [CNT_W-1:0] A0_X4    = 6'h0E;
	localparam logic [CNT_W-1:0] START_X1 = 6'h20;
	localparam logic [CNT_W-1:0] START_X2 = 6'h14;
	localparam logic [CNT_W-1:0] START_X4 = 6'h12;
	localparam logic [IO_W-1:0]  OE_X1    = 4'h2;
	localparam logic [IO_W-1:0]  OE_X2    = 4'h3;
	localparam logic [IO_W-1:0]  OE_X4    = 4'hF;
	localparam logic [3:0]       STEP_X1  = 4'h1;
	localparam logic [3:0]       STEP_X2  = 4'h2;
	localparam logic [3:0]       STEP_X4  = 4'h4;
	localparam logic [TMR_W-1:0] TMR_ONE  = 16'h0001;
	localparam int SLEEP_ENTRY_NS   = 3000;
	localparam int WAKE_NS          = 3000;
	localparam int WAKE_AFTER_ID_NS = 8000;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_ENTER   = 2'b01,
		ST_SLEEP   = 2'b10,
		ST_WAKE    = 2'b11
	} fsi_state_e;

	typedef struct packed {
		logic asleep;
		logic busy;
		logic write_in_progress_flag;
	} fsi_core_s;

	typedef struct packed {
		logic frameTgl;
		logic sleep;
		logic wakeShort;
		logic wakeLong;
	} fsi_rep_s;

	typedef struct packed {
		logic [CNT_W-1:0] start;
		logic [CNT_W-1:0] a0;
		logic [IO_W-1:0]  oe;
		logic [3:0]       step;
	} fsi_lane_s;

	// least time: round up, never below one cycle
	function automatic int nsToCycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : nsToCycles

endpackage : fsi_pkg

// >>> testbench/fsi_host_model.sv
// host serial controller model: select, serial clock and data lines
`timescale 1ns/1ps
`default_nettype none

module fsi_host_model (
	output logic                          sclk,
	output logic                          selectN,
	output logic      [fsi_pkg::IO_W-1:0] ioIn,
	input  wire logic [fsi_pkg::IO_W-1:0] ioOut_q,
	input  wire logic [fsi_pkg::IO_W-1:0] ioOe_q
);
	import fsi_pkg::*;

	localparam time HALF = 16;
	logic [IO_W-1:0] hostOut;
	logic            hostOe;
	logic            oeSeen;
	logic [IO_W-1:0] oeRead;

	// a released line shows the inverse of its last value, not a guess
	always_comb begin
		for (int i = 0; i < IO_W; i++) begin
			ioIn[i] = ioOe_q[i] ? ioOut_q[i] :
				(hostOe ? hostOut[i] : ~hostOut[i]);
		end
	end

	initial begin
		sclk    = 1'b0;
		selectN = 1'b1;
		hostOut = 4'h0;
		hostOe  = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame: command, nPost address/dummy clocks, nRead data clocks
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] cmd, input int nPost, input int a0K,
		input logic a0, input int lanes, input int nRead,
		output logic [31:0] rd);
		rd     = 32'h0;
		oeSeen = 1'b0;
		oeRead = 4'h0;
		selectN = 1'b0;
		// clock stands low outside frames; data changes while it is low
		for (int k = 0; k < 8 + nPost + nRead; k++) begin
			if (k < 8)
				hostOut = {3'b000, cmd[7-k]};
			else if (k < 8 + nPost)
				hostOut = {3'b000, (k == a0K) ? a0 : 1'b0};
			hostOe = (k < 8 + nPost);
			#HALF;
			if (ioOe_q !== 4'h0)
				oeSeen = 1'b1;
			if (k >= 8 + nPost) begin
				oeRead = ioOe_q;
				case (lanes)
					1:       rd = {rd[30:0], ioOut_q[1]};
					2:       rd = {rd[29:0], ioOut_q[1:0]};
					default: rd = {rd[27:0], ioOut_q};
				endcase
			end
			sclk = 1'b1;
			#HALF;
			sclk = 1'b0;
		end
		hostOe = 1'b0;
		#HALF;
		selectN = 1'b1;
	endtask : xfer

endmodule : fsi_host_model
`default_nettype wire

// >>> testbench/test_flash_sleep_and_id_commands.sv
// self-checking bench of the sleep, release and identification logic
`timescale 1ns/1ps
`default_nettype none

module test_flash_sleep_and_id_commands;
	import fsi_pkg::*;

	localparam logic [7:0] MAKER  = 8'h6E; // arbitrary value
	localparam logic [7:0] DEVICE = 8'h1D; // arbitrary value

	logic            ref_clk;
	logic            rstn;
	logic            wipIn;
	wire logic       sclk;
	wire logic       selectN;
	wire logic [3:0] ioIn;
	logic      [3:0] ioOut_q;
	logic      [3:0] ioOe_q;
	logic            wipOut;
	logic            sleepMode;
	logic            cmdGate;
	int              errorCnt;
	int              checked;
	logic [31:0]     rd;
	logic            a0;
	int              m;
	int              off;

	logic [7:0] cmdT[3]   = '{CMD_ID_X1, CMD_ID_X2, CMD_ID_X4};
	int         nPostT[3] = '{24, 12, 10};
	int         a0KT[3]   = '{31, 19, 13};
	int         lanesT[3] = '{1, 2, 4};
	logic [3:0] oeT[3]    = '{4'h2, 4'h3, 4'hF};

	fsi_sleep_id #(
		.MAKER_CODE       (MAKER),
		.DEVICE_CODE      (DEVICE),
		.SLEEP_ENTRY_NS   (40),
		.WAKE_NS          (40),
		.WAKE_AFTER_ID_NS (80)
	) dut (
		.ref_clk              (ref_clk),
		.rstn                 (rstn),
		.sclk                 (sclk),
		.selectN              (selectN),
		.ioIn                 (ioIn),
		.ioOut_q              (ioOut_q),
		.ioOe_q               (ioOe_q),
		.writeInProgressFlag  (wipIn),
		.writeInProgressOut_q (wipOut),
		.sleepMode_q          (sleepMode),
		.cmdGate_q            (cmdGate)
	);

	fsi_host_model host (
		.sclk    (sclk),
		.selectN (selectN),
		.ioIn    (ioIn),
		.ioOut_q (ioOut_q),
		.ioOe_q  (ioOe_q)
	);

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] expId(input logic first);
		logic [15:0] pair;
		pair = first ? {DEVICE, MAKER} : {MAKER, DEVICE};
		return {pair, pair};
	endfunction : expId

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// lets the edge's own updates land before anything is sampled
	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : waitClk

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", errorCnt, checked);
		if (errorCnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic setWip(input logic v);
		@(posedge ref_clk);
		wipIn <= v;
		waitClk(3);
		check(wipOut, v);
	endtask : setWip

	// ----------------------------------------------------------------
	// watchdog: the whole sequence needs well under 100 us
	// ----------------------------------------------------------------
	initial begin
		#200000;
		errorCnt++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn     = 1'b0;
		wipIn    = 1'b0;
		errorCnt = 0;
		checked  = 0;
		void'($urandom(32'hF0EFDF36));
		waitClk(5);
		check({sleepMode, cmdGate, ioOe_q}, 6'h00);
		@(posedge ref_clk);
		rstn <= 1'b1;
		waitClk(4);
		check({sleepMode, cmdGate}, 2'b01);
		// every width with both byte orders, widths rotated from a random start
		off = $urandom_range(2);
		for (int n = 0; n < 6; n++) begin
			m  = (n + off) % 3;
			a0 = (n >= 3);
			host.xfer(cmdT[m], nPostT[m], a0KT[m], a0, lanesT[m],
				32 / lanesT[m], rd);
			check(rd, expId(a0));
			check(host.oeRead, oeT[m]);
			waitClk(8);
			check({ioOe_q, cmdGate}, 5'h01);
		end
		host.xfer(CMD_RELEASE, 24, -1, 1'b0, 1, 32, rd);
		check(rd, {4{DEVICE}});
		waitClk(8);
		// release while awake still runs the wake delay
		host.xfer(CMD_RELEASE, 0, -1, 1'b0, 1, 0, rd);
		waitClk(6);
		check(cmdGate, 1'b0);
		waitClk(30);
		check(cmdGate, 1'b1);
		// a ninth clock cancels the sleep command
		host.xfer(CMD_SLEEP, 1, -1, 1'b0, 1, 0, rd);
		waitClk(40);
		check({sleepMode, cmdGate}, 2'b01);
		// write cycle running: sleep and release both refused
		setWip(1'b1);
		host.xfer(CMD_SLEEP, 0, -1, 1'b0, 1, 0, rd);
		waitClk(40);
		check(sleepMode, 1'b0);
		host.xfer(CMD_RELEASE, 24, -1, 1'b0, 1, 32, rd);
		check(host.oeSeen, 1'b0);
		setWip(1'b0);
		// valid sleep entry takes the entry delay
		host.xfer(CMD_SLEEP, 0, -1, 1'b0, 1, 0, rd);
		waitClk(10);
		check(sleepMode, 1'b0);
		waitClk(30);
		check(sleepMode, 1'b1);
		host.xfer(CMD_ID_X1, 24, 31, 1'b0, 1, 32, rd);
		check(host.oeSeen, 1'b0);
		waitClk(40);
		check(sleepMode, 1'b1);
		// short release: nothing accepted until the wake delay has run
		host.xfer(CMD_RELEASE, 0, -1, 1'b0, 1, 0, rd);
		waitClk(6);
		check(cmdGate, 1'b0);
		waitClk(30);
		check({sleepMode, cmdGate}, 2'b01);
		host.xfer(CMD_SLEEP, 0, -1, 1'b0, 1, 0, rd);
		waitClk(40);
		check(sleepMode, 1'b1);
		// release with read from sleep waits the longer delay
		host.xfer(CMD_RELEASE, 24, -1, 1'b0, 1, 32, rd);
		check(rd, {4{DEVICE}});
		waitClk(18);
		check(cmdGate, 1'b0);
		waitClk(30);
		check({sleepMode, cmdGate}, 2'b01);
		tally_and_finish();
	end

endmodule : test_flash_sleep_and_id_commands
`default_nettype wire
